/* File: pkg/frame_decode_regs.svh */
`ifndef FRAME_DECODE_REGS_SVH
`define FRAME_DECODE_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define ADDR_BITS 32
`define DATA_BITS 32
`define OFFSET_BITS 17
`define FRAME_ID_BITS 5
`define FRAME_COUNT 18

// ----------------------------------------------------------------------------
// Frame spans (log2 of frame size) and implemented sizes
// ----------------------------------------------------------------------------
`define SPAN_128K 5'h11
`define SPAN_4K 5'h0c
`define SPAN_512 5'h09
`define SPAN_256 5'h08
`define SIZE_CAN_RAM 17'h00800
`define SIZE_CONV_RAM 17'h02000
`define SIZE_TIMER_RAM 17'h04000
`define SIZE_TU_RAM 17'h00400
`define SIZE_4K 17'h01000
`define SIZE_512 17'h00200
`define SIZE_256 17'h00100

// ----------------------------------------------------------------------------
// Converter frame layout
// ----------------------------------------------------------------------------
`define CONV_LUT_START 17'h02000
`define CONV_LUT_SIZE 17'h00180
`define CONV_ABORT_START 17'h04000

// ----------------------------------------------------------------------------
// Frame base addresses
// ----------------------------------------------------------------------------
`define BASE_CAN3_RAM 32'hff1a_0000
`define BASE_CAN2_RAM 32'hff1c_0000
`define BASE_CAN1_RAM 32'hff1e_0000
`define BASE_CONV2 32'hff3a_0000
`define BASE_CONV1 32'hff3e_0000
`define BASE_TIMER2_RAM 32'hff44_0000
`define BASE_TIMER1_RAM 32'hff46_0000
`define BASE_TU2_RAM 32'hff4c_0000
`define BASE_TU1_RAM 32'hff4e_0000
`define BASE_DEBUG0 32'hffa0_0000
`define BASE_DEBUG1 32'hffa0_1000
`define BASE_TTU1_REGS 32'hfff7_a400
`define BASE_TTU2_REGS 32'hfff7_a500
`define BASE_TIMER1_REGS 32'hfff7_b800
`define BASE_TIMER2_REGS 32'hfff7_b900
`define BASE_GIO_REGS 32'hfff7_bc00
`define BASE_CONV1_REGS 32'hfff7_c000
`define BASE_CONV2_REGS 32'hfff7_c200

`endif

/* File: pkg/frame_decode_pkg.sv */
package frame_decode_pkg;

    // Answer for locations past the implemented size
    typedef enum logic [1:0] {
        policy_wrap_abort,
        policy_converter,
        policy_zero
    } policy_type;

    typedef struct packed {
        logic [31:0] base;
        logic [4:0] span;
        logic [16:0] actual;
        policy_type policy;
    } frame_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic valid;
        logic error;
        logic [31:0] rdata;
    } bus_rsp_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] frame;
        logic lut;
        logic [16:0] offset;
        logic [31:0] wdata;
    } tgt_req_type;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } tgt_rsp_type;

    typedef enum logic [1:0] {
        kind_forward,
        kind_abort,
        kind_zero
    } kind_type;

    typedef struct packed {
        kind_type kind;
        logic [4:0] frame;
        logic lut;
        logic [16:0] offset;
    } decode_type;

    typedef enum {
        st_idle,
        st_wait
    } state_type;

endpackage

/* File: verilog/frame_decode_unimpl_response.sv */
`include "frame_decode_regs.svh"

module frame_decode_unimpl_response #(
    parameter int DATA_W = `DATA_BITS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Master side
    input frame_decode_pkg::bus_req_type bus_req,
    output logic bus_ready,
    output frame_decode_pkg::bus_rsp_type bus_rsp,
    // Frame side
    output frame_decode_pkg::tgt_req_type tgt_req,
    input frame_decode_pkg::tgt_rsp_type tgt_rsp
);

    if (DATA_W != `DATA_BITS) begin : g_width_check
        $error("DATA_W must match the bus data width");
    end

    // ------------------------------------------------------------------------
    // Frame table
    // ------------------------------------------------------------------------
    localparam frame_decode_pkg::frame_type FRAMES [`FRAME_COUNT] = '{
        '{`BASE_CAN3_RAM, `SPAN_128K, `SIZE_CAN_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_CAN2_RAM, `SPAN_128K, `SIZE_CAN_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_CAN1_RAM, `SPAN_128K, `SIZE_CAN_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_CONV2, `SPAN_128K, `SIZE_CONV_RAM, frame_decode_pkg::policy_converter},
        '{`BASE_CONV1, `SPAN_128K, `SIZE_CONV_RAM, frame_decode_pkg::policy_converter},
        '{`BASE_TIMER2_RAM, `SPAN_128K, `SIZE_TIMER_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_TIMER1_RAM, `SPAN_128K, `SIZE_TIMER_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_TU2_RAM, `SPAN_128K, `SIZE_TU_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_TU1_RAM, `SPAN_128K, `SIZE_TU_RAM, frame_decode_pkg::policy_wrap_abort},
        '{`BASE_DEBUG0, `SPAN_4K, `SIZE_4K, frame_decode_pkg::policy_zero},
        '{`BASE_DEBUG1, `SPAN_4K, `SIZE_4K, frame_decode_pkg::policy_zero},
        '{`BASE_TTU1_REGS, `SPAN_256, `SIZE_256, frame_decode_pkg::policy_zero},
        '{`BASE_TTU2_REGS, `SPAN_256, `SIZE_256, frame_decode_pkg::policy_zero},
        '{`BASE_TIMER1_REGS, `SPAN_256, `SIZE_256, frame_decode_pkg::policy_zero},
        '{`BASE_TIMER2_REGS, `SPAN_256, `SIZE_256, frame_decode_pkg::policy_zero},
        '{`BASE_GIO_REGS, `SPAN_512, `SIZE_256, frame_decode_pkg::policy_zero},
        '{`BASE_CONV1_REGS, `SPAN_512, `SIZE_512, frame_decode_pkg::policy_zero},
        '{`BASE_CONV2_REGS, `SPAN_512, `SIZE_512, frame_decode_pkg::policy_zero}
    };

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] span_mask(input logic [4:0] span);
        span_mask = ~((32'h0000_0001 << span) - 32'h0000_0001);
    endfunction

    // Byte offset of an address inside a frame of the given span
    function automatic logic [16:0] frame_offset(
        input logic [31:0] addr,
        input logic [4:0] span
    );
        logic [31:0] kept;
        kept = addr & ~span_mask(span);
        frame_offset = kept[16:0];
    endfunction

    // Fold an offset onto a power-of-two implemented size
    function automatic logic [16:0] fold(input logic [16:0] off, input logic [16:0] size);
        fold = off & (size - 17'h00001);
    endfunction

    function automatic frame_decode_pkg::decode_type decode(input logic [31:0] addr);
        frame_decode_pkg::decode_type d;
        logic [16:0] off;
        d.kind = frame_decode_pkg::kind_abort;
        d.frame = '0;
        d.lut = 1'b0;
        d.offset = '0;
        off = '0;
        for (int i = 0; i < `FRAME_COUNT; i++) begin
            if ((addr & span_mask(FRAMES[i].span)) == FRAMES[i].base) begin
                off = frame_offset(addr, FRAMES[i].span);
                d.frame = 5'(i);
                case (FRAMES[i].policy)
                    frame_decode_pkg::policy_wrap_abort: begin
                        if (off < FRAMES[i].actual) begin
                            d.kind = frame_decode_pkg::kind_forward;
                            d.offset = fold(off, FRAMES[i].actual);
                        end else begin
                            d.kind = frame_decode_pkg::kind_abort;
                        end
                    end
                    frame_decode_pkg::policy_converter: begin
                        if (off < `CONV_LUT_START) begin
                            d.kind = frame_decode_pkg::kind_forward;
                            d.offset = fold(off, FRAMES[i].actual);
                        end else if (off < `CONV_ABORT_START) begin
                            d.kind = frame_decode_pkg::kind_forward;
                            d.lut = 1'b1;
                            d.offset = (off - `CONV_LUT_START) % `CONV_LUT_SIZE;
                        end else begin
                            d.kind = frame_decode_pkg::kind_abort;
                        end
                    end
                    frame_decode_pkg::policy_zero: begin
                        d.offset = off;
                        if (off < FRAMES[i].actual) begin
                            d.kind = frame_decode_pkg::kind_forward;
                        end else begin
                            d.kind = frame_decode_pkg::kind_zero;
                        end
                    end
                    default: begin
                        d.kind = frame_decode_pkg::kind_abort;
                    end
                endcase
            end
        end
        decode = d;
    endfunction

    // ------------------------------------------------------------------------
    // Frame table checks
    // ------------------------------------------------------------------------
    if (`FRAME_COUNT > (1 << `FRAME_ID_BITS)) begin : g_count_check
        $error("frame index does not fit the frame field");
    end
    for (genvar g = 0; g < `FRAME_COUNT; g++) begin : g_frame_check
        // Folding by masking needs a power-of-two size within the frame
        if ((FRAMES[g].actual & (FRAMES[g].actual - 17'h00001)) != 17'h00000) begin : g_pow2
            $error("implemented size must be a power of two");
        end
        if ({15'h0000, FRAMES[g].actual} > (32'h0000_0001 << FRAMES[g].span)) begin : g_fits
            $error("implemented size exceeds its frame");
        end
        if ((FRAMES[g].base & ~span_mask(FRAMES[g].span)) != 32'h0000_0000) begin : g_align
            $error("frame base must sit on a frame boundary");
        end
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        frame_decode_pkg::state_type state;
        logic ready;
        frame_decode_pkg::bus_rsp_type rsp;
        frame_decode_pkg::tgt_req_type req;
    } regs_type;

    regs_type cur;
    regs_type next_cur;
    frame_decode_pkg::decode_type dec;

    always_comb begin
        next_cur = cur;
        dec = decode(bus_req.addr);
        next_cur.rsp = '0;
        next_cur.req.valid = 1'b0;
        case (cur.state)
            frame_decode_pkg::st_idle: begin
                next_cur.ready = 1'b1;
                if (bus_req.valid && cur.ready) begin
                    next_cur.ready = 1'b0;
                    case (dec.kind)
                        frame_decode_pkg::kind_forward: begin
                            next_cur.state = frame_decode_pkg::st_wait;
                            next_cur.req.valid = 1'b1;
                            next_cur.req.write = bus_req.write;
                            next_cur.req.frame = dec.frame;
                            next_cur.req.lut = dec.lut;
                            next_cur.req.offset = dec.offset;
                            next_cur.req.wdata = bus_req.wdata;
                        end
                        frame_decode_pkg::kind_zero: begin
                            next_cur.rsp.valid = 1'b1;
                        end
                        default: begin
                            next_cur.rsp.valid = 1'b1;
                            next_cur.rsp.error = 1'b1;
                        end
                    endcase
                end
            end
            frame_decode_pkg::st_wait: begin
                next_cur.ready = 1'b0;
                if (tgt_rsp.valid) begin
                    next_cur.state = frame_decode_pkg::st_idle;
                    next_cur.rsp.valid = 1'b1;
                    next_cur.rsp.rdata = tgt_rsp.rdata;
                end
            end
            default: begin
                next_cur.state = frame_decode_pkg::st_idle;
                next_cur.ready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign bus_ready = cur.ready;
    assign bus_rsp = cur.rsp;
    assign tgt_req = cur.req;

endmodule // frame_decode_unimpl_response

/* File: sim/frame_decode_checker.sv */
`include "frame_decode_regs.svh"

module frame_decode_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Master side
    input frame_decode_pkg::bus_req_type bus_req,
    input wire logic bus_ready,
    input frame_decode_pkg::bus_rsp_type bus_rsp,
    // Frame side
    input frame_decode_pkg::tgt_req_type tgt_req,
    input frame_decode_pkg::tgt_rsp_type tgt_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic take;
    logic pend;
    logic [16:0] off;
    logic in_can, in_conv, in_timer, in_gio;
    assign take = bus_req.valid && bus_ready;
    assign off = bus_req.addr[16:0];
    assign in_can = bus_req.addr[31:17] == 15'(`BASE_CAN1_RAM >> 17);
    assign in_conv = bus_req.addr[31:17] == 15'(`BASE_CONV1 >> 17);
    assign in_timer = bus_req.addr[31:17] == 15'(`BASE_TIMER1_RAM >> 17);
    assign in_gio = bus_req.addr[31:9] == 23'(`BASE_GIO_REGS >> 9);

    // Forward in flight
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 1'b0;
        end else if (tgt_req.valid) begin
            pend <= 1'b1;
        end else if (tgt_rsp.valid) begin
            pend <= 1'b0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence abort_done;
        bus_rsp.valid && bus_rsp.error && bus_rsp.rdata == 32'h0 && !tgt_req.valid;
    endsequence
    sequence fwd_issued(logic [16:0] o, logic l);
        tgt_req.valid && !bus_rsp.valid && tgt_req.offset == o && tgt_req.lut == l;
    endsequence

    can_wrap_a: assert property (take && in_can && off < 17'h800 |=>
        fwd_issued(17'($past(off) & 17'h007ff), 1'b0)) else $error("message ram fold wrong");
    can_abort_a: assert property (take && in_can && off >= 17'h800 |=>
        abort_done ##1 !tgt_req.valid) else $error("message ram abort missing");
    conv_ram_a: assert property (take && in_conv && off < 17'h2000 |=>
        fwd_issued(17'($past(off) & 17'h01fff), 1'b0)) else $error("result ram fold wrong");
    lut_wrap_a: assert property (take && in_conv && off >= 17'h2000 && off < 17'h4000 |=>
        fwd_issued(17'(($past(off) - 17'h2000) % 17'h180), 1'b1)) else $error("table wrap wrong");
    conv_abort_a: assert property (take && in_conv && off >= 17'h4000 |=> abort_done)
        else $error("converter abort missing");
    timer_fold_a: assert property (take && in_timer && off < 17'h4000 |=>
        fwd_issued($past(off), 1'b0)) else $error("timer ram forward wrong");
    timer_abort_a: assert property (take && in_timer && off >= 17'h4000 |=> abort_done)
        else $error("timer ram abort missing");
    gio_zero_a: assert property (take && in_gio && bus_req.addr[8] |=> bus_rsp.valid
        && !bus_rsp.error && bus_rsp.rdata == 32'h0 && !tgt_req.valid) else $error("zero answer wrong");
    fwd_data_a: assert property (pend && tgt_rsp.valid |=> bus_rsp.valid && !bus_rsp.error
        && bus_rsp.rdata == $past(tgt_rsp.rdata)) else $error("forward completion wrong");
    take_hold_a: assert property (take |=> !bus_ready)
        else $error("ready stayed high after a take");
    rsp_pulse_a: assert property (bus_rsp.valid |=> !bus_rsp.valid && bus_ready)
        else $error("completion not a single pulse");
endmodule // frame_decode_checker

bind frame_decode_unimpl_response frame_decode_checker u_chk (.core_clk(core_clk),
    .arst_n(arst_n), .bus_req(bus_req), .bus_ready(bus_ready), .bus_rsp(bus_rsp),
    .tgt_req(tgt_req), .tgt_rsp(tgt_rsp));

/* File: sim/frame_partner.sv */
module frame_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Decoder side
    input frame_decode_pkg::tgt_req_type tgt_req,
    output frame_decode_pkg::tgt_rsp_type tgt_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_cnt;

    // Answer one to four cycles late; read data churns while idle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 3'h0;
            tgt_rsp <= '0;
        end else begin
            tgt_rsp.valid <= 1'b0;
            tgt_rsp.rdata <= ~tgt_rsp.rdata;
            if (tgt_req.valid) begin
                wait_cnt <= {1'b0, tgt_req.offset[3:2]} + 3'h1;
            end else if (wait_cnt == 3'h1) begin
                tgt_rsp.valid <= 1'b1;
                tgt_rsp.rdata <= {tgt_req.frame, tgt_req.lut, 9'h0a5, tgt_req.offset};
                wait_cnt <= 3'h0;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule // frame_partner

/* File: sim/frame_decode_unimpl_response_tb.sv */
`include "frame_decode_regs.svh"

module frame_decode_unimpl_response_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    frame_decode_pkg::bus_req_type bus_req = '0;
    logic bus_ready;
    frame_decode_pkg::bus_rsp_type bus_rsp;
    frame_decode_pkg::tgt_req_type tgt_req;
    frame_decode_pkg::tgt_rsp_type tgt_rsp;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    frame_decode_pkg::bus_rsp_type exp_q [$];
    logic [31:0] seed = 32'h8507;
    logic [31:0] bases [18] = '{`BASE_CAN3_RAM, `BASE_CAN2_RAM, `BASE_CAN1_RAM, `BASE_CONV2,
        `BASE_CONV1, `BASE_TIMER2_RAM, `BASE_TIMER1_RAM, `BASE_TU2_RAM, `BASE_TU1_RAM,
        `BASE_DEBUG0, `BASE_DEBUG1, `BASE_TTU1_REGS, `BASE_TTU2_REGS, `BASE_TIMER1_REGS,
        `BASE_TIMER2_REGS, `BASE_GIO_REGS, `BASE_CONV1_REGS, `BASE_CONV2_REGS};
    int span [18] = '{17, 17, 17, 17, 17, 17, 17, 17, 17, 12, 12, 8, 8, 8, 8, 9, 9, 9};
    logic [31:0] edges [15] = '{`BASE_CAN1_RAM + 32'h7fc, `BASE_CAN1_RAM + 32'h800,
        `BASE_CONV1 + 32'h1ffc, `BASE_CONV1 + 32'h2000, `BASE_CONV1 + 32'h217c,
        `BASE_CONV1 + 32'h2180, `BASE_CONV1 + 32'h3ffc, `BASE_CONV1 + 32'h4000,
        `BASE_TIMER2_RAM + 32'h3ffc, `BASE_TIMER2_RAM + 32'h4000, `BASE_TU1_RAM + 32'h3fc,
        `BASE_TU1_RAM + 32'h400, `BASE_GIO_REGS + 32'hfc, `BASE_GIO_REGS + 32'h100, 32'hff30_0000};

    frame_decode_unimpl_response dut (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req),
        .bus_ready(bus_ready), .bus_rsp(bus_rsp), .tgt_req(tgt_req), .tgt_rsp(tgt_rsp));
    frame_partner partner (.core_clk(core_clk), .arst_n(arst_n), .tgt_req(tgt_req),
        .tgt_rsp(tgt_rsp));

    always #50 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Kind 0 forward, 1 abort, 2 zero answer
    function automatic void model(input logic [31:0] a, output int k, f, l, o);
        k = 1;
        f = 0;
        l = 0;
        o = 0;
        for (int i = 0; i < 18; i++) begin
            if (((a ^ bases[i]) >> span[i]) == 0) begin
                f = i;
                o = int'(a - bases[i]);
                k = 0;
                if (i < 3) k = (o >= 'h800) ? 1 : 0;
                else if (i < 5 && o >= 'h4000) k = 1;
                else if (i < 5 && o >= 'h2000) begin
                    l = 1;
                    o = (o - 'h2000) % 'h180;
                end else if (i < 7 && o >= 'h4000) k = 1;
                else if (i > 6 && i < 9 && o >= 'h400) k = 1;
                else if (i == 15 && o >= 'h100) k = 2;
            end
        end
    endfunction

    task automatic chk_rsp(input frame_decode_pkg::bus_rsp_type got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: response %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_fwd(input frame_decode_pkg::tgt_req_type got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: forward %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [31:0] a);
        int k, f, l, o;
        logic [31:0] d;
        frame_decode_pkg::tgt_req_type et;
        frame_decode_pkg::bus_rsp_type er;
        d = rnd();
        model(a, k, f, l, o);
        er = '{1'b1, k == 1, (k == 0) ? {5'(f), 1'(l), 9'h0a5, 17'(o)} : 32'h0};
        exp_q.push_back(er);
        @(posedge core_clk);
        bus_req <= '{1'b1, d[0], a, d};
        do @(negedge core_clk); while (bus_ready !== 1'b1);
        @(posedge core_clk);
        bus_req.valid <= 1'b0;
        @(negedge core_clk);
        et = '{k == 0, d[0], 5'(f), 1'(l), 17'(o), d};
        if (k != 0) begin
            et = tgt_req;
            et.valid = 1'b0;
        end
        chk_fwd(tgt_req, et);
        while (bus_rsp.valid !== 1'b1) @(negedge core_clk);
        chk_rsp(bus_rsp, exp_q.pop_front());
    endtask

    task automatic end_sim();
        $display("Mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] r;
        int unsigned f;
        repeat (4) @(posedge core_clk);
        chk_rsp(bus_rsp, '0);
        arst_n <= 1'b1;
        foreach (edges[i]) xfer(edges[i]);
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(posedge core_clk);
        chk_rsp(bus_rsp, '0);
        arst_n <= 1'b1;
        repeat (400) begin
            r = rnd();
            f = r % 18;
            xfer(bases[f] + (((rnd() & ((32'h1 << span[f]) - 1)) >> r[6:5]) & ~32'h3));
        end
        end_sim();
    end
endmodule // frame_decode_unimpl_response_tb
